/* src/dw_pkg.sv */
package dw_pkg;

    // Target address: fixed upper nibble, strap pins fill the low three bits
    localparam logic [3:0] ADDR_PREFIX = 4'h5;
    localparam int STRAP_W = 3;

    // Command byte codes
    localparam logic [7:0] CMD_WR_A = 8'h11;
    localparam logic [7:0] CMD_WR_B = 8'h12;
    localparam logic [7:0] CMD_WR_AB = 8'h13;

    // Wiper position codes
    localparam logic [7:0] WIPER_RESET = 8'h80;
    localparam logic [7:0] POS_LOW = 8'h00;
    localparam logic [7:0] POS_HIGH = 8'hFF;
    localparam int TAPS = 256;

    // Serial clock cycle numbers within one write transfer
    localparam logic [4:0] CYC_WBIT = 5'h08;
    localparam logic [4:0] CYC_ACK_ADDR = 5'h09;
    localparam logic [4:0] CYC_CMD_LAST = 5'h11;
    localparam logic [4:0] CYC_ACK_CMD = 5'h12;
    localparam logic [4:0] CYC_DATA_LAST = 5'h1A;
    localparam logic [4:0] CYC_ACK_DATA = 5'h1B;
    localparam logic [4:0] CYC_MAX = 5'h1F;

    // Pin synchroniser bank: serial clock, serial data, write-done toggle
    localparam int SYNC_W = 3;
    localparam int SYNC_SCL = 0;
    localparam int SYNC_SDA = 1;
    localparam int SYNC_TOG = 2;

    // Bus framing state seen from the core clock
    typedef enum logic {
        DW_IDLE,
        DW_FRAME
    } dw_frame_t;

endpackage

/* src/dw_sync_if.sv */
interface dw_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] synced;

    // Owner of the asynchronous levels
    modport src (
        output raw,
        input synced
    );

    // The synchroniser itself
    modport sync (
        input raw,
        output synced
    );
endinterface

/* src/dw_sync.sv */
module dw_sync #(
    parameter int W = 1
) (
    input wire logic clk,       // Destination clock
    input wire logic nrst,      // Synchronous reset, active low
    input wire logic ce,        // Clock enable
    dw_sync_if.sync port        // Raw levels in, synchronised levels out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    // Two flip-flops per bit; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                end else if (ce) begin
                    s1_q[i] <= port.raw[i];
                    s2_q[i] <= s1_q[i];
                end
            end
        end
    endgenerate

    assign port.synced = s2_q;
endmodule

/* src/dw_wiper_port.sv */
// What this block does
// - Answer only address 0101 plus strap pins
// - Frame: address, write bit, command, data, acks
// - Command 11h loads data into wiper A
// - Command 12h loads data into wiper B
// - Command 13h loads both wipers together
// - Code 00h selects tap at low end
// - Code FFh selects high-end tap, linear between
// - Both wipers reset to midscale 80h
// - Completed data byte moves wiper at once
// - Write bit high makes transfer a no-op
// - No read path for wiper registers
module dw_wiper_port (
    input wire logic core_clk,                      // Core clock, 125 MHz
    input wire logic nrst,                          // Synchronous reset, active low
    input wire logic ce,                            // Clock enable for core state
    input wire logic scl,                           // Serial clock from the bus master
    input wire logic sda_in,                        // Serial data line level
    output logic sda_out,                           // Serial data drive value, always low
    output logic sda_oe,                            // Serial data pull-down enable
    input wire logic [dw_pkg::STRAP_W-1:0] addr_strap, // addr_strap_2..0 pin levels
    output logic [7:0] wiper_pos_a,                 // Wiper A position register
    output logic [7:0] wiper_pos_b,                 // Wiper B position register
    output logic [dw_pkg::TAPS-1:0] tap_sel_a,      // One-hot tap select, wiper A
    output logic [dw_pkg::TAPS-1:0] tap_sel_b,      // One-hot tap select, wiper B
    output logic frame_busy,                        // Bus between start and stop
    output logic cmd_ignored                        // Pulse: write with unknown command
);

    // ---------------- Core domain: pin synchronisers ----------------
    logic done_tog_q;
    dw_sync_if #(.W(dw_pkg::SYNC_W)) pin_sync ();

    // Serial pins and the link-side toggle all cross here
    assign pin_sync.raw[dw_pkg::SYNC_SCL] = scl;
    assign pin_sync.raw[dw_pkg::SYNC_SDA] = sda_in;
    assign pin_sync.raw[dw_pkg::SYNC_TOG] = done_tog_q;

    dw_sync #(.W(dw_pkg::SYNC_W)) u_sync (
        .clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .port(pin_sync.sync)
    );

    logic scl_s;
    logic sda_s;
    logic tog_s;
    assign scl_s = pin_sync.synced[dw_pkg::SYNC_SCL];
    assign sda_s = pin_sync.synced[dw_pkg::SYNC_SDA];
    assign tog_s = pin_sync.synced[dw_pkg::SYNC_TOG];

    // Previous synchronised levels for edge detection
    logic scl_p_q;
    logic sda_p_q;
    logic tog_p_q;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            tog_p_q <= 1'b0;
        end else if (ce) begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            tog_p_q <= tog_s;
        end
    end

    // Start: data falls while clock high; stop: data rises while clock high
    logic start_det;
    logic stop_det;
    logic write_done;
    assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;
    assign write_done = tog_s ^ tog_p_q;

    // ---------------- Core domain: framing ----------------
    dw_pkg::dw_frame_t frame_q;
    dw_pkg::dw_frame_t frame_d;

    // Next framing state from start and stop conditions
    always_comb begin
        frame_d = frame_q;
        case (frame_q)
            dw_pkg::DW_IDLE: begin
                if (start_det) begin
                    frame_d = dw_pkg::DW_FRAME;
                end
            end
            dw_pkg::DW_FRAME: begin
                if (stop_det) begin
                    frame_d = dw_pkg::DW_IDLE;
                end
            end
            default: begin
                frame_d = dw_pkg::DW_IDLE;
            end
        endcase
    end

    // Link clear holds the serial shifter idle outside frames and pulses
    // on a repeated start, so every frame begins at cycle zero
    logic link_clr_q;
    logic link_rst_q;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            frame_q <= dw_pkg::DW_IDLE;
            link_clr_q <= 1'b1;
        end else if (ce) begin
            frame_q <= frame_d;
            link_clr_q <= (frame_d == dw_pkg::DW_IDLE) ||
                          (start_det && frame_q == dw_pkg::DW_FRAME);
        end
    end

    // Reset for link state that must outlive a frame
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            link_rst_q <= 1'b1;
        end else if (ce) begin
            link_rst_q <= 1'b0;
        end
    end

    // ---------------- Link domain: serial clock ----------------
    logic [4:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [dw_pkg::STRAP_W-1:0] strap_s1_q;
    logic [dw_pkg::STRAP_W-1:0] strap_s2_q;
    logic addr_ok_q;
    logic wr_q;
    logic [7:0] cmd_q;
    logic [7:0] data_q;
    logic [7:0] cmd_hold_q;
    logic [4:0] bit_cnt_d;
    logic [7:0] byte_in;

    assign bit_cnt_d = (bit_cnt_q == dw_pkg::CYC_MAX) ? bit_cnt_q : bit_cnt_q + 5'h01;
    assign byte_in = {shift_q, sda_in};

    // Bit counter, shifter and strap synchroniser, cleared between frames
    always_ff @(posedge scl or posedge link_clr_q) begin
        if (link_clr_q) begin
            bit_cnt_q <= 5'h00;
            shift_q <= 7'h00;
            strap_s1_q <= '0;
            strap_s2_q <= '0;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            shift_q <= byte_in[6:0];
            strap_s1_q <= addr_strap;
            strap_s2_q <= strap_s1_q;
        end
    end

    // Address match and write bit, judged at the eighth clock
    always_ff @(posedge scl or posedge link_clr_q) begin
        if (link_clr_q) begin
            addr_ok_q <= 1'b0;
            wr_q <= 1'b0;
            cmd_q <= 8'h00;
        end else begin
            if (bit_cnt_d == dw_pkg::CYC_WBIT) begin
                addr_ok_q <= (shift_q == {dw_pkg::ADDR_PREFIX, strap_s2_q});
                wr_q <= !sda_in;
            end
            if (bit_cnt_d == dw_pkg::CYC_CMD_LAST) begin
                cmd_q <= byte_in;
            end
        end
    end

    // Completed data byte handed over with a toggle; kept across frames
    always_ff @(posedge scl or posedge link_rst_q) begin
        if (link_rst_q) begin
            data_q <= 8'h00;
            cmd_hold_q <= 8'h00;
            done_tog_q <= 1'b0;
        end else if (bit_cnt_d == dw_pkg::CYC_DATA_LAST && addr_ok_q && wr_q) begin
            data_q <= byte_in;
            cmd_hold_q <= cmd_q;
            done_tog_q <= !done_tog_q;
        end
    end

    // Acknowledge: pull data low from the falling edge after cycles 8, 17
    // and 26 to the next falling edge; only the address ack on a no-op
    logic sda_oe_q;
    always_ff @(negedge scl or posedge link_clr_q) begin
        if (link_clr_q) begin
            sda_oe_q <= 1'b0;
        end else begin
            sda_oe_q <= addr_ok_q && ((bit_cnt_q == dw_pkg::CYC_WBIT) ||
                        (wr_q && (bit_cnt_q == dw_pkg::CYC_CMD_LAST ||
                                  bit_cnt_q == dw_pkg::CYC_DATA_LAST)));
        end
    end

    // ---------------- Core domain: wiper registers ----------------
    logic load_a;
    logic load_b;
    logic bad_cmd;

    // Command decode on each completed write
    always_comb begin
        load_a = 1'b0;
        load_b = 1'b0;
        bad_cmd = 1'b0;
        if (write_done) begin
            case (cmd_hold_q)
                dw_pkg::CMD_WR_A: load_a = 1'b1;
                dw_pkg::CMD_WR_B: load_b = 1'b1;
                dw_pkg::CMD_WR_AB: begin
                    load_a = 1'b1;
                    load_b = 1'b1;
                end
                default: bad_cmd = 1'b1;
            endcase
        end
    end

    logic [7:0] pos_a_q;
    logic [7:0] pos_b_q;
    logic [7:0] pos_a_d;
    logic [7:0] pos_b_d;
    assign pos_a_d = load_a ? data_q : pos_a_q;
    assign pos_b_d = load_b ? data_q : pos_b_q;

    // Position registers, write-only from the bus, midscale after reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pos_a_q <= dw_pkg::WIPER_RESET;
            pos_b_q <= dw_pkg::WIPER_RESET;
        end else if (ce) begin
            pos_a_q <= pos_a_d;
            pos_b_q <= pos_b_d;
        end
    end

    // One-hot tap selects: code 00h is tap 0 at the low terminal, FFh the
    // last tap at the high terminal, codes between map straight to taps
    logic [dw_pkg::TAPS-1:0] tap_a_q;
    logic [dw_pkg::TAPS-1:0] tap_b_q;
    genvar t;
    generate
        for (t = 0; t < dw_pkg::TAPS; t++) begin : g_tap
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    tap_a_q[t] <= (dw_pkg::WIPER_RESET == 8'(t));
                    tap_b_q[t] <= (dw_pkg::WIPER_RESET == 8'(t));
                end else if (ce) begin
                    tap_a_q[t] <= (pos_a_d == 8'(t));
                    tap_b_q[t] <= (pos_b_d == 8'(t));
                end
            end
        end
    endgenerate

    // Status flags and the constant-low data drive
    logic busy_q;
    logic ignored_q;
    logic sda_out_q;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            ignored_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else if (ce) begin
            busy_q <= (frame_d == dw_pkg::DW_FRAME);
            ignored_q <= bad_cmd;
            sda_out_q <= 1'b0;
        end
    end

    // Outputs straight from flip-flops; nothing drives wiper data onto the bus
    assign sda_out = sda_out_q;
    assign sda_oe = sda_oe_q;
    assign wiper_pos_a = pos_a_q;
    assign wiper_pos_b = pos_b_q;
    assign tap_sel_a = tap_a_q;
    assign tap_sel_b = tap_b_q;
    assign frame_busy = busy_q;
    assign cmd_ignored = ignored_q;

endmodule

/* tb/dw_wiper_port_assertions.sv */
module dw_wiper_port_assertions (
    input wire logic core_clk, // Core clock
    input wire logic nrst, // Reset, active low
    input wire logic ce, // Clock enable
    input wire logic scl, // Serial clock
    input wire logic sda_in, // Data wire level
    input wire logic sda_out, // Data drive value
    input wire logic sda_oe, // Data pull-down enable
    input wire logic [dw_pkg::STRAP_W-1:0] addr_strap, // Strap pins
    input wire logic [7:0] wiper_pos_a, // Wiper A
    input wire logic [7:0] wiper_pos_b, // Wiper B
    input wire logic [dw_pkg::TAPS-1:0] tap_sel_a, // Taps A
    input wire logic [dw_pkg::TAPS-1:0] tap_sel_b, // Taps B
    input wire logic frame_busy, // Frame open
    input wire logic cmd_ignored // Unknown command pulse
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // Reset loads midscale whatever the bus does
    wiper_reset_a: assert property (disable iff (1'b0) !nrst |=>
        wiper_pos_a == dw_pkg::WIPER_RESET && wiper_pos_b == dw_pkg::WIPER_RESET)
        else $error("wiper not midscale after reset");
    // Tap select follows the code, low end at 00h
    tap_map_wa_a: assert property (tap_sel_a == (256'h1 << wiper_pos_a))
        else $error("tap select A does not match code");
    tap_map_wb_a: assert property (tap_sel_b == (256'h1 << wiper_pos_b))
        else $error("tap select B does not match code");
    // Wipers move only inside a transfer
    wiper_in_frame_a: assert property (!$stable(wiper_pos_a) || !$stable(wiper_pos_b)
        |-> frame_busy) else $error("wiper moved outside a frame");
    ignore_keeps_a: assert property (cmd_ignored |->
        $stable(wiper_pos_a) && $stable(wiper_pos_b)) else $error("unknown command moved wiper");
    ignore_pulse_a: assert property (cmd_ignored |=> !cmd_ignored)
        else $error("ignore flag longer than one cycle");
    ack_in_frame_a: assert property (sda_oe |-> frame_busy)
        else $error("data pulled low outside a frame");
    ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("acknowledge too short");
    data_low_a: assert property (sda_out == 1'b0)
        else $error("data line driven high");
endmodule

bind dw_wiper_port dw_wiper_port_assertions u_dw_wiper_port_assertions (.core_clk, .nrst,
    .ce, .scl, .sda_in, .sda_out, .sda_oe, .addr_strap, .wiper_pos_a, .wiper_pos_b,
    .tap_sel_a, .tap_sel_b, .frame_busy, .cmd_ignored);

/* tb/dw_bus_master.sv */
module dw_bus_master (
    output logic scl, // Serial clock, idle high
    output logic sda_low, // High pulls data low
    input wire logic sda // Resolved data level
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bus idle: both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Start, n clocks of address, command and data with acks, then stop
    task automatic xfer(input logic [23:0] v, input int n, output logic [2:0] ack);
        ack = 3'h0;
        sda_low = 1'b1;
        #40;
        for (int i = 0; i < n; i++) begin
            scl = 1'b0;
            #20;
            // Data changes only while the clock is low; released on ack cycles
            sda_low = (i % 9 == 8) ? 1'b0 : !v[23 - (i / 9) * 8 - i % 9];
            #20;
            scl = 1'b1;
            #20;
            if (i % 9 == 8) begin
                ack[2 - i / 9] = !sda;
            end
            #20;
        end
        // Stop: data rises while clock high
        scl = 1'b0;
        #20;
        sda_low = 1'b1;
        #20;
        scl = 1'b1;
        #20;
        sda_low = 1'b0;
        #40;
    endtask
endmodule

/* tb/dw_wiper_port_tb_top.sv */
module dw_wiper_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [2:0] strap;
        logic [23:0] v;
        logic [7:0] ea;
        logic [7:0] eb;
        logic [2:0] eack;
        logic eign;
    } dw_row_t;

    // Straps, address+cmd+data, expected wipers, acks, ignore flag
    dw_row_t rows [8] = '{
        '{3'h0, 24'h50113C, 8'h3C, 8'h80, 3'h7, 1'b0},
        '{3'h5, 24'h5A12FF, 8'h3C, 8'hFF, 3'h7, 1'b0},
        '{3'h7, 24'h5E1300, 8'h00, 8'h00, 3'h7, 1'b0},
        '{3'h2, 24'h542255, 8'h00, 8'h00, 3'h7, 1'b1},
        '{3'h3, 24'h571177, 8'h00, 8'h00, 3'h4, 1'b0},
        '{3'h4, 24'h501177, 8'h00, 8'h00, 3'h0, 1'b0},
        '{3'h6, 24'h5C1181, 8'h81, 8'h00, 3'h7, 1'b0},
        '{3'h1, 24'h52127F, 8'h81, 8'h7F, 3'h7, 1'b0}};

    logic core_clk, nrst, ce, scl, sda_low, sda_in, sda_out, sda_oe, frame_busy;
    logic cmd_ignored;
    logic [2:0] addr_strap, ack;
    logic [7:0] wiper_pos_a, wiper_pos_b;
    logic [255:0] tap_sel_a, tap_sel_b;
    int err_total = 0;
    int samples_checked = 0;
    int ign_cnt = 0;
    int ign_base = 0;

    // Open-drain data wire with pull-up
    assign sda_in = !(sda_low | sda_oe);

    dw_bus_master u_dw_bus_master (.scl(scl), .sda_low(sda_low), .sda(sda_in));

    dw_wiper_port u_dw_wiper_port (.core_clk(core_clk), .nrst(nrst), .ce(ce), .scl(scl),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
        .wiper_pos_a(wiper_pos_a), .wiper_pos_b(wiper_pos_b), .tap_sel_a(tap_sel_a),
        .tap_sel_b(tap_sel_b), .frame_busy(frame_busy), .cmd_ignored(cmd_ignored));

    // Core clock, 8 ns
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = !core_clk;
    end

    // Count ignore pulses; a row expects none or exactly one
    always @(posedge core_clk) begin
        if (cmd_ignored === 1'b1) begin
            ign_cnt <= ign_cnt + 1;
        end
    end

    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic do_reset;
        @(posedge core_clk) #1 nrst = 1'b0;
        repeat (8) @(posedge core_clk);
        #1 nrst = 1'b1;
        // No start until the pin synchronisers have refilled
        repeat (4) @(posedge core_clk);
        #1;
        check(wiper_pos_a, 8'h80);
        check(wiper_pos_b, 8'h80);
        check(tap_sel_a, 256'h1 << 128);
        check(tap_sel_b, 256'h1 << 128);
        check(frame_busy, 1'b0);
    endtask

    // Hang guard
    initial begin
        #200000;
        err_total++;
        end_sim;
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        addr_strap = 3'h0;
        do_reset;
        // Table of whole transfers
        foreach (rows[r]) begin
            @(posedge core_clk) #1 addr_strap = rows[r].strap;
            ign_base = ign_cnt;
            u_dw_bus_master.xfer(rows[r].v, 27, ack);
            repeat (4) @(posedge core_clk);
            #1;
            check(ack, rows[r].eack);
            check(wiper_pos_a, rows[r].ea);
            check(wiper_pos_b, rows[r].eb);
            check(tap_sel_a, 256'h1 << rows[r].ea);
            check(tap_sel_b, 256'h1 << rows[r].eb);
            check(ign_cnt - ign_base, rows[r].eign);
            check(frame_busy, 1'b0);
            check(sda_out, 1'b0);
        end
        // Stop after 20 clocks: data byte never completes
        u_dw_bus_master.xfer(24'h5211AA, 20, ack);
        repeat (4) @(posedge core_clk);
        #1;
        check(ack, 3'h6);
        check(wiper_pos_a, 8'h81);
        check(wiper_pos_b, 8'h7F);
        // Second reset in mid-run, then a write must still land
        do_reset;
        fork
            u_dw_bus_master.xfer(24'h5211AA, 27, ack);
            begin
                repeat (20) @(posedge core_clk);
                #1 check(frame_busy, 1'b1);
            end
        join
        repeat (4) @(posedge core_clk);
        #1;
        check(ack, 3'h7);
        check(wiper_pos_a, 8'hAA);
        check(wiper_pos_b, 8'h80);
        end_sim;
    end
endmodule
